/* core/tmpc_timer.sv */
// 16-bit timer mode, polarity, prescale and conversion snapshot logic
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

// Behaviour
// - run bit low stops, high runs mode
// - disabled output follows the polarity bit
// - one-shot output pulses one cycle after reload
// - other non-PWM counting modes toggle output on reload
// - counter mode counts polarity-selected input edges
// - single PWM: reload sets, match restores level
// - capture modes capture on polarity-selected edge
// - gated mode counts active level, irq inactive edge
// - capture/compare starts on first edge, then captures
// - dual PWM complement inverse, rising edges delayed
// - triggered one-shot starts on polarity-selected edge
// - prescaler divides by two to the field
// - prescaler cleared while the timer is disabled
// - four-bit mode code selects twelve modes
// - conversion start snapshots count, held until next
// - mode top bit lives in control register a
// - deadband field gives zero or 2..128 cycles
module tmpc_timer (
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic [11:0] reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        timer_in_pin_i,
	input  wire logic        comparator_i,
	input  wire logic        adc_start_i,
	input  wire logic [15:0] reload_value_i,
	input  wire logic [15:0] pwm_value_i,
	output logic             timer_out_o,
	output logic             timer_out_n_o,
	output logic      [15:0] count_o,
	output logic      [15:0] capture_o,
	output logic             irq_o
);

	// software registers
	logic [7:0]                 timer_control_a;
	logic [7:0]                 timer_control_b;
	logic [3:0]                 irq_status;
	logic [3:0]                 irq_mask;
	logic                       capture_flag;
	logic [15:0]                snapshot;

	// decoded fields
	logic                       timer_run_bit;
	logic                       io_polarity_bit;
	logic [2:0]                 prescale_field;
	logic [3:0]                 operating_select_field;
	logic                       input_select_bit;
	logic [2:0]                 deadband_delay_field;

	// input synchronisers and edges
	logic                       pin_meta;
	logic                       pin_sync;
	logic                       cmp_meta;
	logic                       cmp_sync;
	logic                       sel_in;
	logic                       sel_prev;
	logic                       rise_edge;
	logic                       fall_edge;
	logic                       active_edge;
	logic                       inactive_edge;
	logic                       gate_open;

	// local alias of the phase type
	typedef tmpc_pkg::tmpc_phase_t tmpc_phase_t;

	// counting engine
	logic [tmpc_pkg::PRES_W-1:0] prescale_cnt;
	logic [tmpc_pkg::PRES_W-1:0] prescale_mask;
	logic                       prescale_tick;
	tmpc_phase_t                phase;
	logic [15:0]                count;
	logic                       advance;
	logic                       reload_evt;
	logic                       match_evt;
	logic                       capture_evt;
	logic                       restart_evt;
	logic                       stops_on_reload;
	logic                       is_pwm;
	logic                       timer_out_raw;
	logic                       db_true;
	logic                       db_comp;
	logic [3:0]                 irq_events;

	// field decode
	assign timer_run_bit          = timer_control_b[tmpc_pkg::CTLB_RUN_BIT];
	assign io_polarity_bit        = timer_control_b[tmpc_pkg::CTLB_POL_BIT];
	assign prescale_field         = timer_control_b[tmpc_pkg::CTLB_PRES_HI:tmpc_pkg::CTLB_PRES_LO];
	assign operating_select_field = {timer_control_a[tmpc_pkg::CTLA_TOP_BIT],
		timer_control_b[tmpc_pkg::CTLB_MODE_HI:tmpc_pkg::CTLB_MODE_LO]};
	assign input_select_bit       = timer_control_a[tmpc_pkg::CTLA_INSEL];
	assign deadband_delay_field   = timer_control_a[tmpc_pkg::CTLA_DB_HI:tmpc_pkg::CTLA_DB_LO];

	// two-stage synchronisers for pin and comparator
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			pin_meta <= timer_in_pin_i;
			pin_sync <= pin_meta;
			cmp_meta <= comparator_i;
			cmp_sync <= cmp_meta;
		end
	end

	// previous value of the selected input
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			sel_prev <= 1'b0;
		end else begin
			sel_prev <= sel_in;
		end
	end

	// edge classification by polarity
	assign sel_in        = input_select_bit ? cmp_sync : pin_sync;
	assign rise_edge     = sel_in & ~sel_prev;
	assign fall_edge     = ~sel_in & sel_prev;
	assign active_edge   = io_polarity_bit ? fall_edge : rise_edge;
	assign inactive_edge = io_polarity_bit ? rise_edge : fall_edge;
	assign gate_open     = sel_in ^ io_polarity_bit;

	// prescaler, held clear while stopped
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			prescale_cnt <= '0;
		end else if (!timer_run_bit) begin
			prescale_cnt <= '0;
		end else begin
			prescale_cnt <= prescale_cnt + 7'h01;
		end
	end

	// tick once every two to the field cycles
	assign prescale_mask = tmpc_pkg::PRES_W'((16'h0001 << prescale_field) - 16'h0001);
	assign prescale_tick = timer_run_bit & ((prescale_cnt & prescale_mask) == prescale_mask);

	// per-mode count qualification
	always_comb begin
		case (operating_select_field)
			tmpc_pkg::MODE_COUNTER: advance = timer_run_bit & active_edge;
			tmpc_pkg::MODE_GATED:   advance = prescale_tick & gate_open;
			tmpc_pkg::MODE_CAPCMP:  advance = prescale_tick & (phase == tmpc_pkg::TMPC_PH_RUN);
			tmpc_pkg::MODE_TRIGOS:  advance = prescale_tick & (phase == tmpc_pkg::TMPC_PH_RUN);
			tmpc_pkg::MODE_ONESHOT,
			tmpc_pkg::MODE_CONT,
			tmpc_pkg::MODE_PWM1,
			tmpc_pkg::MODE_CAPTURE,
			tmpc_pkg::MODE_COMPARE,
			tmpc_pkg::MODE_PWM2,
			tmpc_pkg::MODE_CAPRST,
			tmpc_pkg::MODE_CMPCNT:  advance = prescale_tick;
			default:                advance = 1'b0;
		endcase
	end

	// capture qualification per mode
	always_comb begin
		case (operating_select_field)
			tmpc_pkg::MODE_CAPTURE,
			tmpc_pkg::MODE_CAPRST,
			tmpc_pkg::MODE_CMPCNT:  capture_evt = timer_run_bit & active_edge;
			tmpc_pkg::MODE_CAPCMP:  capture_evt = timer_run_bit & active_edge &
				(phase == tmpc_pkg::TMPC_PH_RUN);
			default:                capture_evt = 1'b0;
		endcase
	end

	// events derived from the count
	assign reload_evt      = advance & (count == reload_value_i);
	assign match_evt       = advance & (count == pwm_value_i);
	assign restart_evt     = capture_evt & (operating_select_field == tmpc_pkg::MODE_CAPRST);
	assign stops_on_reload = (operating_select_field == tmpc_pkg::MODE_ONESHOT) |
		(operating_select_field == tmpc_pkg::MODE_TRIGOS);
	assign is_pwm          = (operating_select_field == tmpc_pkg::MODE_PWM1) |
		(operating_select_field == tmpc_pkg::MODE_PWM2);

	// wait-for-edge phase of capture/compare and triggered one-shot
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			phase <= tmpc_pkg::TMPC_PH_WAIT;
		end else begin
			case (phase)
				tmpc_pkg::TMPC_PH_WAIT: begin
					if (timer_run_bit && active_edge) begin
						phase <= tmpc_pkg::TMPC_PH_RUN;
					end
				end
				tmpc_pkg::TMPC_PH_RUN: begin
					if (!timer_run_bit) begin
						phase <= tmpc_pkg::TMPC_PH_WAIT;
					end
				end
				default: phase <= tmpc_pkg::TMPC_PH_WAIT;
			endcase
		end
	end

	// 16-bit count, restarts at one on reload
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			count <= tmpc_pkg::COUNT_RST;
		end else if (restart_evt) begin
			count <= tmpc_pkg::COUNT_RST;
		end else if (reload_evt) begin
			count <= tmpc_pkg::COUNT_RST;
		end else if (advance) begin
			count <= count + 16'h0001;
		end
	end

	// input capture value
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			capture_o <= tmpc_pkg::SNAP_RST;
		end else if (capture_evt) begin
			capture_o <= count;
		end
	end

	// last interrupt cause: set by capture, cleared by reload
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			capture_flag <= 1'b0;
		end else if (capture_evt) begin
			capture_flag <= 1'b1;
		end else if (reload_evt) begin
			capture_flag <= 1'b0;
		end
	end

	// timer output level before deadband
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			timer_out_raw <= 1'b0;
		end else if (!timer_run_bit) begin
			timer_out_raw <= io_polarity_bit;
		end else if (is_pwm) begin
			if (reload_evt) begin
				timer_out_raw <= ~io_polarity_bit;
			end else if (match_evt) begin
				timer_out_raw <= io_polarity_bit;
			end
		end else if (reload_evt) begin
			timer_out_raw <= ~timer_out_raw;
		end
	end

	// deadband on each output of the dual pair
	tmpc_deadband u_db_true (
		.core_clk_i  (core_clk_i),
		.rst_b_i     (rst_b_i),
		.level_i     (timer_out_raw),
		.delay_sel_i (deadband_delay_field),
		.level_o     (db_true)
	);
	tmpc_deadband u_db_comp (
		.core_clk_i  (core_clk_i),
		.rst_b_i     (rst_b_i),
		.level_i     (~timer_out_raw),
		.delay_sel_i (deadband_delay_field),
		.level_o     (db_comp)
	);

	// pin drivers; dual mode takes the deadband pair while the run bit is set
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			timer_out_o   <= 1'b0;
			timer_out_n_o <= 1'b1;
		end else if (timer_run_bit && operating_select_field == tmpc_pkg::MODE_PWM2) begin
			timer_out_o   <= db_true;
			timer_out_n_o <= db_comp;
		end else begin
			timer_out_o   <= timer_out_raw;
			timer_out_n_o <= ~timer_out_raw;
		end
	end

	// conversion-start snapshot of the count
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			snapshot <= tmpc_pkg::SNAP_RST;
		end else if (adc_start_i) begin
			snapshot <= count;
		end
	end

	// control register a; bit 0 is hardware status
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			timer_control_a <= tmpc_pkg::CTL_A_RST;
		end else if (reg_wr_i && reg_addr_i == tmpc_pkg::ADDR_CTL_A) begin
			timer_control_a <= {reg_wdata_i[7:1], 1'b0};
		end
	end

	// control register b; one-shot modes drop the run bit on reload
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			timer_control_b <= tmpc_pkg::CTL_B_RST;
		end else if (reg_wr_i && reg_addr_i == tmpc_pkg::ADDR_CTL_B) begin
			timer_control_b <= reg_wdata_i;
		end else if (reload_evt && stops_on_reload) begin
			timer_control_b[tmpc_pkg::CTLB_RUN_BIT] <= 1'b0;
		end
	end

	// interrupt events
	always_comb begin
		irq_events                        = '0;
		irq_events[tmpc_pkg::IRQ_RELOAD]  = reload_evt;
		irq_events[tmpc_pkg::IRQ_CAPTURE] = capture_evt;
		irq_events[tmpc_pkg::IRQ_GATE]    = timer_run_bit & inactive_edge &
			(operating_select_field == tmpc_pkg::MODE_GATED);
		irq_events[tmpc_pkg::IRQ_SNAP]    = adc_start_i;
	end

	// sticky status, write one to clear, new event wins
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			irq_status <= tmpc_pkg::STATUS_RST;
		end else if (reg_wr_i && reg_addr_i == tmpc_pkg::ADDR_STATUS) begin
			irq_status <= (irq_status & ~reg_wdata_i[3:0]) | irq_events;
		end else begin
			irq_status <= irq_status | irq_events;
		end
	end

	// interrupt mask
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			irq_mask <= tmpc_pkg::MASK_RST;
		end else if (reg_wr_i && reg_addr_i == tmpc_pkg::ADDR_MASK) begin
			irq_mask <= reg_wdata_i[3:0];
		end
	end

	assign irq_o = |(irq_status & irq_mask);

	// read data, one cycle after the strobe
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= tmpc_pkg::RD_IDLE;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				tmpc_pkg::ADDR_CTL_A:  reg_rdata_o <= {timer_control_a[7:1], capture_flag};
				tmpc_pkg::ADDR_CTL_B:  reg_rdata_o <= timer_control_b;
				tmpc_pkg::ADDR_SNAP_H: reg_rdata_o <= snapshot[15:8];
				tmpc_pkg::ADDR_SNAP_L: reg_rdata_o <= snapshot[7:0];
				tmpc_pkg::ADDR_STATUS: reg_rdata_o <= {4'h0, irq_status};
				tmpc_pkg::ADDR_MASK:   reg_rdata_o <= {4'h0, irq_mask};
				default:               reg_rdata_o <= tmpc_pkg::RD_IDLE;
			endcase
		end else begin
			reg_rdata_o <= tmpc_pkg::RD_IDLE;
		end
	end

	// live count for the excluded count registers
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			count_o <= tmpc_pkg::COUNT_RST;
		end else begin
			count_o <= count;
		end
	end

endmodule

/* core/tmpc_pkg.sv */
// constants, mode codes and register map of the timer mode and polarity block
package tmpc_pkg;

	// bus and datapath widths
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned PRES_W = 7;
	localparam int unsigned DB_W   = 8;
	localparam int unsigned IRQ_W  = 4;

	// register addresses
	localparam logic [11:0] ADDR_CTL_A  = 12'hF06;
	localparam logic [11:0] ADDR_CTL_B  = 12'hF07;
	localparam logic [11:0] ADDR_SNAP_H = 12'hF08;
	localparam logic [11:0] ADDR_SNAP_L = 12'hF09;
	localparam logic [11:0] ADDR_STATUS = 12'hF0E;
	localparam logic [11:0] ADDR_MASK   = 12'hF0F;

	// timer_control_a fields
	localparam int unsigned CTLA_TOP_BIT  = 7;
	localparam int unsigned CTLA_INSEL    = 4;
	localparam int unsigned CTLA_DB_HI    = 3;
	localparam int unsigned CTLA_DB_LO    = 1;
	localparam int unsigned CTLA_CAPFLAG  = 0;

	// timer_control_b fields
	localparam int unsigned CTLB_RUN_BIT  = 7;
	localparam int unsigned CTLB_POL_BIT  = 6;
	localparam int unsigned CTLB_PRES_HI  = 5;
	localparam int unsigned CTLB_PRES_LO  = 3;
	localparam int unsigned CTLB_MODE_HI  = 2;
	localparam int unsigned CTLB_MODE_LO  = 0;

	// reset values
	localparam logic [7:0]  CTL_A_RST  = 8'h00;
	localparam logic [7:0]  CTL_B_RST  = 8'h00;
	localparam logic [3:0]  STATUS_RST = 4'h0;
	localparam logic [3:0]  MASK_RST   = 4'h0;
	localparam logic [15:0] COUNT_RST  = 16'h0001;
	localparam logic [15:0] SNAP_RST   = 16'h0000;
	localparam logic [7:0]  RD_IDLE    = 8'h00;

	// interrupt status bit positions
	localparam int unsigned IRQ_RELOAD  = 0;
	localparam int unsigned IRQ_CAPTURE = 1;
	localparam int unsigned IRQ_GATE    = 2;
	localparam int unsigned IRQ_SNAP    = 3;

	// operating mode codes
	localparam logic [3:0] MODE_ONESHOT  = 4'h0;
	localparam logic [3:0] MODE_CONT     = 4'h1;
	localparam logic [3:0] MODE_COUNTER  = 4'h2;
	localparam logic [3:0] MODE_PWM1     = 4'h3;
	localparam logic [3:0] MODE_CAPTURE  = 4'h4;
	localparam logic [3:0] MODE_COMPARE  = 4'h5;
	localparam logic [3:0] MODE_GATED    = 4'h6;
	localparam logic [3:0] MODE_CAPCMP   = 4'h7;
	localparam logic [3:0] MODE_PWM2     = 4'h8;
	localparam logic [3:0] MODE_CAPRST   = 4'h9;
	localparam logic [3:0] MODE_CMPCNT   = 4'hA;
	localparam logic [3:0] MODE_TRIGOS   = 4'hB;

	// deadband code meaning no added delay
	localparam logic [2:0] DB_NONE = 3'h0;

	// start-up phase for modes that wait on an input edge
	typedef enum {
		TMPC_PH_WAIT,
		TMPC_PH_RUN
	} tmpc_phase_t;

endpackage

/* core/tmpc_deadband.sv */
// deadband stage delaying only the rising edge of one output
`timescale 1ns/1ps
module tmpc_deadband (
	input  wire logic       core_clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       level_i,
	input  wire logic [2:0] delay_sel_i,
	output logic            level_o
);

	logic [tmpc_pkg::DB_W-1:0] wait_cnt;
	logic [tmpc_pkg::DB_W-1:0] target;

	// zero or two to the code cycles of dead time
	always_comb begin
		if (delay_sel_i == tmpc_pkg::DB_NONE) begin
			target = '0;
		end else begin
			target = tmpc_pkg::DB_W'(32'h0000_0001 << delay_sel_i);
		end
	end

	// fall at once, rise only after the wait has run out
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			wait_cnt <= '0;
			level_o  <= 1'b0;
		end else if (!level_i) begin
			wait_cnt <= '0;
			level_o  <= 1'b0;
		end else if (wait_cnt >= target) begin
			level_o  <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 8'h01;
		end
	end

endmodule

/* verification/tmpc_timer_assertions.sv */
// port checker of the timer mode and polarity block
`timescale 1ns/1ps
module tmpc_timer_chk (
	input wire logic        core_clk_i,
	input wire logic        rst_b_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        timer_in_pin_i,
	input wire logic        comparator_i,
	input wire logic        adc_start_i,
	input wire logic [15:0] reload_value_i,
	input wire logic [15:0] pwm_value_i,
	input wire logic        timer_out_o,
	input wire logic        timer_out_n_o,
	input wire logic [15:0] count_o,
	input wire logic [15:0] capture_o,
	input wire logic        irq_o
);
	logic [7:0]  ctla_q;
	logic [7:0]  ctlb_q;
	logic        adc_q;
	logic [15:0] snap_q;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	// shadows of control writes and the expected snapshot
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			ctla_q <= tmpc_pkg::CTL_A_RST;
			ctlb_q <= tmpc_pkg::CTL_B_RST;
			adc_q  <= 1'b0;
			snap_q <= tmpc_pkg::SNAP_RST;
		end else begin
			if (reg_wr_i && reg_addr_i == tmpc_pkg::ADDR_CTL_A) ctla_q <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == tmpc_pkg::ADDR_CTL_B) ctlb_q <= reg_wdata_i;
			adc_q <= adc_start_i;
			if (adc_q) snap_q <= count_o;
		end
	end
	// a write that clears the run bit, then a quiet bus
	sequence s_stop_write;
		reg_wr_i && reg_addr_i == tmpc_pkg::ADDR_CTL_B && !reg_wdata_i[7];
	endsequence
	sequence s_bus_quiet;
		!reg_wr_i [*4];
	endsequence
	chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == tmpc_pkg::RD_IDLE)
		else $error("read data not idle");
	chk_ctlb_readback: assert property (reg_rd_i && reg_addr_i == tmpc_pkg::ADDR_CTL_B
		|=> reg_rdata_o[6:0] == ctlb_q[6:0]) else $error("control b readback wrong");
	chk_ctla_readback: assert property (reg_rd_i && reg_addr_i == tmpc_pkg::ADDR_CTL_A
		|=> reg_rdata_o[7:1] == ctla_q[7:1]) else $error("control a readback wrong");
	chk_snap_high: assert property (reg_rd_i && reg_addr_i == tmpc_pkg::ADDR_SNAP_H && !adc_start_i
		|=> reg_rdata_o == snap_q[15:8]) else $error("snapshot high byte wrong");
	chk_snap_low: assert property (reg_rd_i && reg_addr_i == tmpc_pkg::ADDR_SNAP_L && !adc_start_i
		|=> reg_rdata_o == snap_q[7:0]) else $error("snapshot low byte wrong");
	chk_stop_holds: assert property (s_stop_write ##1 s_bus_quiet |-> $stable(count_o))
		else $error("count moved while stopped");
	chk_stop_level: assert property (s_stop_write ##1 s_bus_quiet |-> timer_out_o == ctlb_q[6])
		else $error("stopped output not at polarity");
	chk_oneshot_pulse: assert property (!ctla_q[7] && ctlb_q[2:0] == 3'h0 && !ctlb_q[6]
		&& $rose(timer_out_o) |=> $fell(timer_out_o)) else $error("one-shot pulse not one cycle");
	chk_dual_apart: assert property (ctla_q[7] && ctlb_q[2:0] == 3'h0
		|-> !(timer_out_o && timer_out_n_o)) else $error("output and complement both high");
endmodule

bind tmpc_timer tmpc_timer_chk u_chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.timer_in_pin_i(timer_in_pin_i), .comparator_i(comparator_i), .adc_start_i(adc_start_i),
	.reload_value_i(reload_value_i), .pwm_value_i(pwm_value_i), .timer_out_o(timer_out_o),
	.timer_out_n_o(timer_out_n_o), .count_o(count_o), .capture_o(capture_o), .irq_o(irq_o));

/* verification/tmpc_partner.sv */
// model of the input pin, comparator and conversion start
`timescale 1ns/1ps
module tmpc_partner (
	input  wire logic core_clk_i,
	output logic      pin_o,
	output logic      cmp_o,
	output logic      adc_start_o
);
	// idle levels from time zero
	initial begin
		pin_o = 1'b0;
		cmp_o = 1'b0;
		adc_start_o = 1'b0;
	end
	// move pin or comparator just after an edge
	task automatic set_in(input logic use_cmp, input logic lvl);
		@(posedge core_clk_i);
		if (use_cmp) cmp_o <= lvl;
		else pin_o <= lvl;
	endtask
	// one-cycle conversion start, return just past its taking edge
	task automatic adc_pulse();
		@(posedge core_clk_i);
		adc_start_o <= 1'b1;
		@(posedge core_clk_i);
		adc_start_o <= 1'b0;
		#1;
	endtask
endmodule

/* verification/testbench.sv */
// self-checking bench of the timer mode and polarity block
`timescale 1ns/1ps
module testbench;
	logic        core_clk_i;
	logic        rst_b_i;
	logic [11:0] reg_addr_i;
	logic [7:0]  reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [7:0]  reg_rdata_o;
	logic        timer_in_pin_i;
	logic        comparator_i;
	logic        adc_start_i;
	logic [15:0] reload_value_i;
	logic [15:0] pwm_value_i;
	logic        timer_out_o;
	logic        timer_out_n_o;
	logic [15:0] count_o;
	logic [15:0] capture_o;
	logic        irq_o;
	logic [15:0] v;
	int          n;
	int          mismatches = 0;
	int          n_compared = 0;
	int          cycles = 0;
	tmpc_timer u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.timer_in_pin_i(timer_in_pin_i), .comparator_i(comparator_i), .adc_start_i(adc_start_i),
		.reload_value_i(reload_value_i), .pwm_value_i(pwm_value_i), .timer_out_o(timer_out_o),
		.timer_out_n_o(timer_out_n_o), .count_o(count_o), .capture_o(capture_o), .irq_o(irq_o));
	tmpc_partner u_partner (.core_clk_i(core_clk_i), .pin_o(timer_in_pin_i), .cmp_o(comparator_i),
		.adc_start_o(adc_start_i));
	// 40 MHz clock
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	// hang guard
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic final_report();
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk_i);
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// read and compare the data of the following cycle
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		check({8'h00, reg_rdata_o}, {8'h00, exp});
	endtask
	// length in cycles of the next full high pulse of output or complement
	task automatic hold_len(input logic sel, output int len);
		int k;
		k = 0;
		len = 0;
		for (int ph = 0; ph < 3; ph++) begin
			while (((sel ? timer_out_n_o : timer_out_o) === (ph != 1)) && k < 600) begin
				@(posedge core_clk_i);
				k++;
				if (ph == 2) len++;
			end
		end
	endtask
	task automatic t_reset();
		rd(tmpc_pkg::ADDR_CTL_B, tmpc_pkg::CTL_B_RST);
		rd(tmpc_pkg::ADDR_CTL_A, tmpc_pkg::CTL_A_RST);
		rd(12'hF0A, 8'h00);
		check({14'h0, timer_out_o, timer_out_n_o}, 16'h0001);
		check(count_o, tmpc_pkg::COUNT_RST);
		for (int p = 1; p >= 0; p--) begin
			wr(tmpc_pkg::ADDR_CTL_B, {1'b0, p[0], 6'h00});
			cyc(4);
			check({14'h0, timer_out_o, timer_out_n_o}, {14'h0, p[0], !p[0]});
		end
	endtask
	task automatic t_cont();
		reload_value_i <= 16'h0004;
		wr(tmpc_pkg::ADDR_CTL_B, 8'h91);
		hold_len(1'b0, n);
		check(n[15:0], 16'h0010);
		wr(tmpc_pkg::ADDR_CTL_B, 8'h11);
		cyc(3);
		v = count_o;
		cyc(10);
		check(count_o, v);
		wr(tmpc_pkg::ADDR_CTL_B, 8'h91);
		cyc(4);
		check(count_o, v);
		cyc(1);
		check(count_o, (v == 16'h0004) ? 16'h0001 : v + 16'h0001);
		wr(tmpc_pkg::ADDR_CTL_B, 8'h00);
	endtask
	task automatic t_oneshot();
		wr(tmpc_pkg::ADDR_STATUS, 8'h0F);
		wr(tmpc_pkg::ADDR_MASK, 8'h01);
		wr(tmpc_pkg::ADDR_CTL_B, 8'h80);
		hold_len(1'b0, n);
		check(n[15:0], 16'h0001);
		rd(tmpc_pkg::ADDR_CTL_B, 8'h00);
		check({15'h0, irq_o}, 16'h0001);
		wr(tmpc_pkg::ADDR_MASK, 8'h00);
		cyc(1);
		check({15'h0, irq_o}, 16'h0000);
		wr(tmpc_pkg::ADDR_MASK, 8'h01);
		wr(tmpc_pkg::ADDR_STATUS, 8'h01);
		cyc(1);
		check({15'h0, irq_o}, 16'h0000);
		rd(tmpc_pkg::ADDR_STATUS, 8'h00);
	endtask
	task automatic t_counter();
		reload_value_i <= 16'hFFFF;
		wr(tmpc_pkg::ADDR_CTL_B, 8'hC2);
		cyc(2);
		v = count_o;
		u_partner.set_in(1'b0, 1'b1);
		cyc(6);
		check(count_o, v);
		u_partner.set_in(1'b0, 1'b0);
		cyc(6);
		check(count_o, v + 16'h0001);
		wr(tmpc_pkg::ADDR_CTL_B, 8'h00);
	endtask
	task automatic t_capture();
		logic [7:0] ca [3] = '{8'h00, 8'h80, 8'h90};
		logic [7:0] cb [3] = '{8'h84, 8'h81, 8'h82};
		for (int i = 0; i < 3; i++) begin
			wr(tmpc_pkg::ADDR_CTL_A, ca[i]);
			wr(tmpc_pkg::ADDR_CTL_B, cb[i]);
			cyc(4);
			v = capture_o;
			u_partner.set_in(ca[i][4], 1'b1);
			cyc(6);
			check({15'h0, capture_o != v}, 16'h0001);
			rd(tmpc_pkg::ADDR_CTL_A, ca[i] | 8'h01);
			v = capture_o;
			u_partner.set_in(ca[i][4], 1'b0);
			cyc(6);
			check(capture_o, v);
			wr(tmpc_pkg::ADDR_CTL_B, 8'h00);
		end
		wr(tmpc_pkg::ADDR_CTL_A, 8'h00);
	endtask
	task automatic t_gated();
		wr(tmpc_pkg::ADDR_STATUS, 8'h0F);
		wr(tmpc_pkg::ADDR_CTL_B, 8'h86);
		cyc(4);
		v = count_o;
		cyc(4);
		check(count_o, v);
		u_partner.set_in(1'b0, 1'b1);
		cyc(8);
		check({15'h0, count_o != v}, 16'h0001);
		u_partner.set_in(1'b0, 1'b0);
		cyc(6);
		rd(tmpc_pkg::ADDR_STATUS, 8'h04);
		wr(tmpc_pkg::ADDR_CTL_B, 8'h00);
	endtask
	task automatic t_trig();
		wr(tmpc_pkg::ADDR_CTL_A, 8'h80);
		wr(tmpc_pkg::ADDR_CTL_B, 8'hC3);
		cyc(4);
		v = count_o;
		u_partner.set_in(1'b0, 1'b1);
		cyc(6);
		check(count_o, v);
		u_partner.set_in(1'b0, 1'b0);
		cyc(6);
		check({15'h0, count_o != v}, 16'h0001);
		wr(tmpc_pkg::ADDR_CTL_B, 8'h00);
		wr(tmpc_pkg::ADDR_CTL_A, 8'h00);
	endtask
	task automatic t_snap();
		wr(tmpc_pkg::ADDR_CTL_B, 8'h81);
		cyc(5);
		u_partner.adc_pulse();
		v = count_o;
		cyc(5);
		wr(tmpc_pkg::ADDR_SNAP_H, 8'hAA);
		rd(tmpc_pkg::ADDR_SNAP_H, v[15:8]);
		rd(tmpc_pkg::ADDR_SNAP_L, v[7:0]);
		wr(tmpc_pkg::ADDR_CTL_B, 8'h00);
	endtask
	task automatic t_pwm();
		// mid-run reset so the count starts below the reload value
		@(posedge core_clk_i);
		rst_b_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		cyc(2);
		check(count_o, tmpc_pkg::COUNT_RST);
		reload_value_i <= 16'h0014;
		wr(tmpc_pkg::ADDR_CTL_B, 8'h83);
		hold_len(1'b0, n);
		check(n[15:0], 16'h0008);
		wr(tmpc_pkg::ADDR_CTL_B, 8'hC3);
		hold_len(1'b1, n);
		check(n[15:0], 16'h0008);
		wr(tmpc_pkg::ADDR_CTL_B, 8'h00);
		wr(tmpc_pkg::ADDR_CTL_A, 8'h84);
		wr(tmpc_pkg::ADDR_CTL_B, 8'h80);
		hold_len(1'b0, n);
		check(n[15:0], 16'h0004);
		hold_len(1'b1, n);
		check(n[15:0], 16'h0008);
		wr(tmpc_pkg::ADDR_CTL_B, 8'h00);
		wr(tmpc_pkg::ADDR_CTL_A, 8'h00);
	endtask
	// reset, then every scenario in turn
	initial begin
		rst_b_i = 1'b0;
		reg_addr_i = 12'h000;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reload_value_i = 16'hFFFF;
		pwm_value_i = 16'h0008;
		repeat (16) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		cyc(2);
		t_reset();
		t_cont();
		t_oneshot();
		t_counter();
		t_capture();
		t_gated();
		t_trig();
		t_snap();
		t_pwm();
		final_report();
	end
endmodule
